// ==== ecpp_periph_model.sv ====
// peripheral model for the parallel port: forward capture, reverse send
// assumes pins synchronous to pclk; the bench fills send and reads got
`default_nettype none
module ecpp_periph_model (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic [7:0] pd_out,
    input  wire logic       pd_oe_n,
    input  wire logic       host_clock_strobe_n,
    input  wire logic       host_ack_autofeed_n,
    input  wire logic       reverse_request_init_n,
    input  wire logic       ecp_mode_select_in_n,
    input  wire logic [3:0] slow,
    output logic      [7:0] pd_in,
    output logic            periph_clock_ack_n,
    output logic            peripheral_ack_busy,
    output logic            ack_reverse_a
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [8:0] got[$];  // forward words, bit 8 = autofeed level
    logic [8:0] send[$]; // reverse words, bit 8 = busy level
    logic [3:0] wcnt;    // stall before busy rises
    logic [7:0] drv;     // byte this side drives
    logic       drv_on;  // this side owns the lines
    logic       clash;   // both sides drove at once
    // undriven lines show the inverse of the last byte, never a stale copy
    assign pd_in = !pd_oe_n ? pd_out : (drv_on ? drv : ~drv);
    // one process keeps both directions of the link
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            periph_clock_ack_n  <= 1'b1;
            peripheral_ack_busy <= 1'b0;
            ack_reverse_a       <= 1'b1;
            wcnt                <= 4'h0;
            drv                 <= 8'h00;
            drv_on              <= 1'b0;
            clash               <= 1'b0;
        end else begin
            ack_reverse_a <= reverse_request_init_n;
            if (!pd_oe_n && drv_on) clash <= 1'b1;
            if (reverse_request_init_n) begin
                drv_on <= 1'b0;
                if (!host_clock_strobe_n && !peripheral_ack_busy) begin
                    // capture on strobe, optionally stall first
                    if (wcnt == slow) begin
                        got.push_back({host_ack_autofeed_n, pd_out});
                        peripheral_ack_busy <= 1'b1;
                        wcnt <= 4'h0;
                    end else wcnt <= wcnt + 4'h1;
                end else if (host_clock_strobe_n && peripheral_ack_busy) begin
                    peripheral_ack_busy <= 1'b0;
                end
            end else if (!ack_reverse_a) begin
                if (!host_ack_autofeed_n && ecp_mode_select_in_n && periph_clock_ack_n
                    && send.size() > 0 && !drv_on) begin
                    drv                 <= send[0][7:0];
                    peripheral_ack_busy <= send[0][8];
                    drv_on              <= 1'b1;
                end else if (drv_on && periph_clock_ack_n && !host_ack_autofeed_n) begin
                    periph_clock_ack_n <= 1'b0;
                end else if (!periph_clock_ack_n && host_ack_autofeed_n) begin
                    periph_clock_ack_n <= 1'b1;
                    drv_on             <= 1'b0;
                    void'(send.pop_front());
                end
            end
        end
    end
endmodule
`default_nettype wire

// ==== ecpp_pkg.sv ====
// types shared by the parallel port: engine states and the state record
// assumes the register header is on the include path
`default_nettype none
package ecpp_pkg;
`include "ecpp_regs.svh"
    // link engine states, gray along the forward path and from request to repeat; reverse returns to idle are not
    typedef enum logic [2:0] {
        ECPP_IDLE  = 3'h0,
        ECPP_F_SET = 3'h1,
        ECPP_F_STB = 3'h3,
        ECPP_F_REL = 3'h2,
        ECPP_R_REQ = 3'h4,
        ECPP_R_CAP = 3'h5,
        ECPP_R_REP = 3'h7
    } ecpp_state_e;
    // whole state of the port
    typedef struct packed {
        logic [7:0]       data;    // spp data latch
        logic [5:0]       dcr;     // control bits
        logic [2:0]       mode;    // extended control mode
        logic             nerr_en; // error interrupt enable, active low
        logic             dma_en;  // dma request enable
        logic             svc;     // service bit
        logic [15:0][8:0] mem;     // shared fifo, bit 8 = address tag
        logic [4:0]       wp;      // write pointer
        logic [4:0]       rp;      // read pointer
        logic [7:0]       last;    // last byte read by the bus
        ecpp_state_e      st;      // link engine state
        logic [7:0]       pd;      // byte on the data lines
        logic             tag;     // forward byte is an address
        logic [6:0]       rle;     // run length / repeats left
        logic             rle_pend;// a run length waits for its byte
        logic [31:0]      rdata;   // apb read data
    } ecpp_state_s;
endpackage
`default_nettype wire

// ==== ecpp_port.sv ====
// extended capabilities parallel port: apb registers, shared fifo, link engine
// assumes peripheral pins synchronous to pclk; testbench resolves the data wire
//
// How it works
// - every port word is eight bits wide
// - one shared sixteen byte fifo for all
// - status and control readable in every mode
// - run length byte repeats next data byte
// - transmit compression optional, not built here
// - no negotiation; dma burst channel both ways
// - compat fifo mode strobes bytes automatically
// - forward data then strobe, interlocked with busy
// - autofeed requests each reverse byte, interlocked
// - forward autofeed marks address versus data
// - init low means reverse, high forward
// - drive data only when acknowledge permits
// - select-in stays high during ecp mode
// - fault low raises error interrupt; here only in ecp forward
// - configuration b reports chosen irq, dma
// - three bit mode field selects port mode
// - direction bit ignored in modes 000, 010
//
// Added by the designer: the APB slave port and the placing of the registers.
`default_nettype none
// register indices and field positions
`include "ecpp_regs.svh"
module ecpp_port (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [12:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic [7:0]  pd_in,
    output logic      [7:0]  pd_out,
    output logic             pd_oe_n,
    output logic             host_clock_strobe_n,
    output logic             host_ack_autofeed_n,
    output logic             reverse_request_init_n,
    output logic             ecp_mode_select_in_n,
    input  wire logic        periph_clock_ack_n,
    input  wire logic        peripheral_ack_busy,
    input  wire logic        ack_reverse_a,
    input  wire logic        periph_request_fault_n,
    input  wire logic        printer_select,
    input  wire logic [2:0]  cfg_irq_sel,
    input  wire logic [2:0]  cfg_dma_sel,
    output logic             err_irq,
    output logic             dma_req
);
    import ecpp_pkg::*;

    // registered and next state, and combinational views of the state, recomputed every cycle
    ecpp_state_s q;      // registered state
    ecpp_state_s n;      // next state
    logic [4:0]  cnt;    // fifo fill
    logic        full;   // fifo full
    logic        empty;  // fifo empty
    logic        ecp;    // ecp mode
    logic        rev;    // reverse direction requested
    logic        fwd_ok; // forward engine may run
    logic        rev_ok; // reverse engine may run
    logic        acc;    // apb access phase
    logic        hit;    // address mapped
    logic [7:0]  head;   // byte seen at the fifo read side

    // register index match on a word address
    // a byte address off the word grid matches nothing and is refused
    function automatic logic at(input logic [12:0] a, input logic [10:0] idx);
        at = (a == {idx, 2'b00});
    endfunction

    // fifo status and direction
    always_comb begin
        // pointers carry one spare bit so that full and empty differ
        cnt    = q.wp - q.rp;
        full   = (cnt == `ECPP_FIFO_DEPTH);
        empty  = (cnt == 5'h00);
        ecp    = (q.mode == `ECPP_MODE_ECP);
        rev    = ecp && q.dcr[`ECPP_DCR_DIR];
        // ecp forward waits until the peripheral has handed the lines back
        fwd_ok = (q.mode == `ECPP_MODE_COMPAT_DATA_FIFO_PORT) || (ecp && !rev && ack_reverse_a);
        rev_ok = rev && !ack_reverse_a;
        acc    = psel && penable;
        hit    = at(paddr, `ECPP_IDX_DATA) || at(paddr, `ECPP_IDX_DSR)
              || at(paddr, `ECPP_IDX_DCR) || at(paddr, `ECPP_IDX_FIFO)
              || at(paddr, `ECPP_IDX_CAPABILITY_B) || at(paddr, `ECPP_IDX_ECR);
        // an empty fifo shows the last byte read, for the test reread
        head   = empty ? q.last : q.mem[q.rp[3:0]][7:0];
    end

    // apb answer: zero wait, error on unmapped address
    // reads never stall: the value was captured in the setup cycle
    always_comb begin
        pready  = acc;
        pslverr = acc && !hit;
        prdata  = q.rdata;
    end

    // pin outputs per mode
    // outside the link modes the control bits reach the pins as written
    always_comb begin
        host_clock_strobe_n    = ~q.dcr[`ECPP_DCR_STB];
        host_ack_autofeed_n    = ~q.dcr[`ECPP_DCR_AFD];
        reverse_request_init_n = q.dcr[`ECPP_DCR_INIT];
        ecp_mode_select_in_n   = ~q.dcr[`ECPP_DCR_SEL];
        pd_out                 = q.data;
        pd_oe_n                = q.dcr[`ECPP_DCR_DIR];
        // modes 000 and 010 always drive outward
        if (q.mode == `ECPP_MODE_SPP || q.mode == `ECPP_MODE_COMPAT_DATA_FIFO_PORT) begin
            pd_oe_n = 1'b0;
        end
        if (q.mode == `ECPP_MODE_COMPAT_DATA_FIFO_PORT || ecp) begin
            pd_out              = q.pd;
            host_clock_strobe_n = (q.st != ECPP_F_STB);
        end
        // ecp owns select-in, init and the data direction
        if (ecp) begin
            ecp_mode_select_in_n   = 1'b1;
            reverse_request_init_n = !rev;
            pd_oe_n                = rev || !ack_reverse_a;
            // reverse: request byte; forward: low marks an address
            host_ack_autofeed_n = rev ? (q.st != ECPP_R_REQ) : !q.tag;
        end
        // test mode shows the fifo head on the lines
        if (q.mode == `ECPP_MODE_TEST) begin
            pd_out = head;
        end
        // error interrupt is a plain level, forward direction only
        err_irq = ecp && !rev && !periph_request_fault_n && !q.nerr_en;
        // dma asks for room going out and for data coming in
        dma_req = q.dma_en
               && (rev ? !empty : ((fwd_ok || q.mode == `ECPP_MODE_TEST) && !full));
    end

    // next state: bus access, fifo and link engine
    always_comb begin
        logic       push;
        logic       pop;
        logic [8:0] pdat;
        logic [7:0] rv;
        push = 1'b0;
        pop  = 1'b0;
        pdat = 9'h000;
        rv   = 8'h00;
        n    = q;

        // read value mux, captured in the setup cycle
        if (at(paddr, `ECPP_IDX_DATA)) begin
            rv = pd_in;
        end else if (at(paddr, `ECPP_IDX_DSR)) begin
            // live pin levels, nothing latched
            rv = {!peripheral_ack_busy, periph_clock_ack_n, ack_reverse_a,
                  printer_select, periph_request_fault_n, 3'h0};
        end else if (at(paddr, `ECPP_IDX_DCR)) begin
            rv = {2'h0, q.dcr};
        end else if (at(paddr, `ECPP_IDX_FIFO)) begin
            rv = (q.mode == `ECPP_MODE_CFG) ? `ECPP_CAPABILITY_A_VAL : head;
        end else if (at(paddr, `ECPP_IDX_CAPABILITY_B)) begin
            // no transmit compression built
            rv = {1'b0, err_irq, cfg_irq_sel, cfg_dma_sel};
        end else if (at(paddr, `ECPP_IDX_ECR)) begin
            rv = {q.mode, q.nerr_en, q.dma_en, q.svc, full, empty};
        end
        if (psel && !penable) begin
            n.rdata = {24'h000000, rv};
        end

        // bus writes
        if (acc && pwrite) begin
            if (at(paddr, `ECPP_IDX_DATA)) begin
                if (q.mode == `ECPP_MODE_SPP || q.mode == `ECPP_MODE_BIDIR) begin
                    n.data = pwdata[7:0];
                end else if (ecp && !rev && !full) begin
                    push = 1'b1; // address or run length byte
                    pdat = {1'b1, pwdata[7:0]};
                end
            end
            // control bits are writable in every mode
            if (at(paddr, `ECPP_IDX_DCR)) begin
                n.dcr = pwdata[5:0];
            end
            if (at(paddr, `ECPP_IDX_FIFO) && !full) begin
                if (q.mode == `ECPP_MODE_COMPAT_DATA_FIFO_PORT || q.mode == `ECPP_MODE_TEST
                    || (ecp && !rev)) begin
                    push = 1'b1; // full fifo drops the byte
                    pdat = {1'b0, pwdata[7:0]};
                end
            end
            // full and empty are read only and ignore the write
            if (at(paddr, `ECPP_IDX_ECR)) begin
                n.mode    = pwdata[7:5];
                n.nerr_en = pwdata[4];
                n.dma_en  = pwdata[3];
                n.svc     = pwdata[2];
                // entering 000 or 001 flushes the fifo
                if (pwdata[7:6] == 2'h0) begin
                    n.rp = q.wp;
                end
            end
        end

        // bus reads from the fifo; empty test fifo rereads last byte
        if (acc && !pwrite && at(paddr, `ECPP_IDX_FIFO) && !empty) begin
            if (rev || q.mode == `ECPP_MODE_TEST) begin
                pop    = 1'b1;
                n.last = q.mem[q.rp[3:0]][7:0];
            end
        end

        // link engine
        case (q.st)
            // idle: forward work wins over a reverse request
            ECPP_IDLE: begin
                if (fwd_ok && !empty) begin
                    pop   = 1'b1;
                    n.pd  = q.mem[q.rp[3:0]][7:0];
                    n.tag = ecp && q.mem[q.rp[3:0]][8];
                    n.st  = ECPP_F_SET;
                end else if (rev_ok && !full) begin
                    n.tag = 1'b0;
                    n.st  = ECPP_R_REQ;
                end
            end
            // data goes out one cycle before strobe falls
            ECPP_F_SET: begin
                n.st = ECPP_F_STB; // data settles before strobe
            end
            // strobe stays low until busy answers
            ECPP_F_STB: begin
                if (peripheral_ack_busy) begin
                    n.st = ECPP_F_REL;
                end
            end
            // strobe high again until busy drops
            ECPP_F_REL: begin
                if (!peripheral_ack_busy) begin
                    n.st = ECPP_IDLE;
                end
            end
            // autofeed low asks the peripheral for a byte
            ECPP_R_REQ: begin
                if (!periph_clock_ack_n) begin
                    n.st = ECPP_R_CAP;
                    if (!peripheral_ack_busy) begin
                        // command byte: run length or channel address
                        if (!pd_in[`ECPP_RLE_BIT]) begin
                            n.rle      = pd_in[6:0];
                            n.rle_pend = 1'b1;
                        end
                    end else begin
                        push = 1'b1;
                        pdat = {1'b0, pd_in};
                        n.pd = pd_in;
                        if (!q.rle_pend) begin
                            n.rle = 7'h00;
                        end
                        n.rle_pend = 1'b0;
                    end
                end
            end
            // wait for the peripheral to release its clock
            ECPP_R_CAP: begin
                if (periph_clock_ack_n) begin
                    // a run length alone waits for its data byte before any repeat
                    if (q.rle != 7'h00 && !q.rle_pend) begin
                        n.st = ECPP_R_REP;
                    end else begin
                        n.st = ECPP_IDLE;
                    end
                end
            end
            // repeat the held byte once per cycle with room
            ECPP_R_REP: begin
                if (!full) begin
                    push  = 1'b1;
                    pdat  = {1'b0, q.pd};
                    n.rle = q.rle - 7'h01;
                    if (q.rle == 7'h01) begin
                        n.st = ECPP_IDLE;
                    end
                end
            end
            // unused codes fall back to idle
            default: begin
                n.st = ECPP_IDLE;
            end
        endcase
        // leaving the link modes aborts the engine
        if (q.mode != `ECPP_MODE_COMPAT_DATA_FIFO_PORT && !ecp) begin
            n.st = ECPP_IDLE;
        end

        // shared fifo update
        // both writers test full first, so a push never lands on unread data
        if (push) begin
            n.mem[q.wp[3:0]] = pdat;
            n.wp = q.wp + 5'h01;
        end
        if (pop) begin
            n.rp = n.rp + 5'h01;
        end
    end

    // state register; reset leaves forward, empty, idle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            // everything not named here clears with the record
            q         <= '0;
            q.dcr     <= `ECPP_DCR_RST;
            q.mode    <= `ECPP_MODE_SPP;
            q.nerr_en <= 1'b1;
            q.st      <= ECPP_IDLE;
        end else begin
            q <= n;
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_fifo_bound: assert property (cnt <= `ECPP_FIFO_DEPTH)
        else $error("fifo fill above depth");
    a_selin_ecp: assert property (ecp |-> ecp_mode_select_in_n)
        else $error("select-in asserted in ecp mode");
    a_init_dir: assert property (ecp |-> (reverse_request_init_n == !q.dcr[`ECPP_DCR_DIR]))
        else $error("init does not follow direction");
    a_data_drive: assert property (ecp && !pd_oe_n |-> ack_reverse_a && !rev)
        else $error("data driven without permission");
    a_fwd_strobe: assert property (q.st == ECPP_F_SET |=> !host_clock_strobe_n)
        else $error("strobe missing after data setup");
    a_strobe_hold: assert property (q.st == ECPP_F_STB && !peripheral_ack_busy
                                    && (ecp || q.mode == `ECPP_MODE_COMPAT_DATA_FIFO_PORT)
                                    |=> q.st == ECPP_F_STB)
        else $error("strobe released before busy");
    a_rev_req: assert property (rev && q.st == ECPP_R_REQ |-> !host_ack_autofeed_n)
        else $error("reverse request not on autofeed");
    a_err_irq: assert property (ecp && !rev && !periph_request_fault_n && !q.nerr_en
                                |-> err_irq)
        else $error("fault did not raise interrupt");
    a_spp_out: assert property (q.mode == `ECPP_MODE_SPP || q.mode == `ECPP_MODE_COMPAT_DATA_FIFO_PORT
                                |-> !pd_oe_n)
        else $error("port not driving in output only mode");
    a_rle_push: assert property (q.st == ECPP_R_REP && !full |=> $changed(q.wp))
        else $error("run length repeat not pushed");
    // link handshake checks
    a_fwd_pop: assert property (q.st == ECPP_IDLE && fwd_ok && !empty
                                |=> q.st == ECPP_F_SET)
        else $error("queued forward byte not taken");
    a_release_hold: assert property (q.st == ECPP_F_REL && peripheral_ack_busy
                                     && (ecp || q.mode == `ECPP_MODE_COMPAT_DATA_FIFO_PORT)
                                     |=> q.st == ECPP_F_REL)
        else $error("strobe cycle ended while busy");
    a_rev_hold: assert property (q.st == ECPP_R_CAP && !periph_clock_ack_n && ecp
                                 |=> q.st == ECPP_R_CAP)
        else $error("reverse byte released early");
    a_rev_push: assert property (q.st == ECPP_R_REQ && !periph_clock_ack_n
                                 && peripheral_ack_busy |=> $changed(q.wp))
        else $error("reverse data byte not stored");
    a_rle_count: assert property (q.st == ECPP_R_REP && !full
                                  |=> q.rle == $past(q.rle) - 7'h01)
        else $error("run length not counted down");
    a_rle_wait: assert property (q.st == ECPP_R_CAP && q.rle_pend
                                 |=> q.st != ECPP_R_REP)
        else $error("repeat started before data byte");
    a_rev_hiz: assert property (ecp && rev |-> pd_oe_n)
        else $error("data driven in reverse");
endmodule
`default_nettype wire

// ==== ecpp_regs.svh ====
// register indices, mode codes, field positions and reset values of the port
// assumes byte address = 4 * register index on a 32-bit apb bus
`ifndef ECPP_REGS_SVH
`define ECPP_REGS_SVH
`define ECPP_IDX_DATA   11'h000
`define ECPP_IDX_DSR    11'h001
`define ECPP_IDX_DCR    11'h002
`define ECPP_IDX_FIFO   11'h400
`define ECPP_IDX_CAPABILITY_B  11'h401
`define ECPP_IDX_ECR    11'h402
`define ECPP_MODE_SPP   3'h0
`define ECPP_MODE_BIDIR 3'h1
`define ECPP_MODE_COMPAT_DATA_FIFO_PORT 3'h2
`define ECPP_MODE_ECP   3'h3
`define ECPP_MODE_TEST  3'h6
`define ECPP_MODE_CFG   3'h7
`define ECPP_DCR_STB    0
`define ECPP_DCR_AFD    1
`define ECPP_DCR_INIT   2
`define ECPP_DCR_SEL    3
`define ECPP_DCR_DIR    5
`define ECPP_DCR_RST    6'h00
`define ECPP_ECR_RST    6'h04
`define ECPP_CAPABILITY_A_VAL  8'h10
`define ECPP_FIFO_DEPTH 5'h10
`define ECPP_RLE_BIT    7
`endif

// ==== tb_top.sv ====
// testbench: apb register tests of the parallel port with a peripheral model
// assumes ecpp_pkg, ecpp_port and ecpp_periph_model are compiled first
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [12:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic [7:0]  pd_in, pd_out;
    logic        pd_oe_n, host_clock_strobe_n, host_ack_autofeed_n, e;
    logic        reverse_request_init_n, ecp_mode_select_in_n, periph_clock_ack_n;
    logic        peripheral_ack_busy, ack_reverse_a, periph_request_fault_n;
    logic        printer_select, err_irq, dma_req;
    logic [2:0]  cfg_irq_sel, cfg_dma_sel;
    logic [3:0]  slow;
    int          err_count, tests_run, i;
    ecpp_port         ecpp_port_i (.*);
    ecpp_periph_model ecpp_periph_model_i (.*);
    // free running bus clock, 50 ns
    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end
    // counts, verdict and end of run
    task automatic stop_test;
        $display("checks %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic check(input string n, input logic [31:0] s, input logic [31:0] x);
        tests_run++;
        if (s !== x) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", n, x, s);
        end
    endtask
    // one apb transfer, entered just after a rising edge
    task automatic apb(input logic w, input logic [12:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        q = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        if (n == 50) begin
            err_count++;
            stop_test();
        end
        @(posedge pclk);
    endtask
    task automatic rd(input string n, input logic [12:0] a, input logic [31:0] x);
        apb(1'b0, a, 32'h0);
        check(n, q, x);
    endtask
    // bounded wait for the link to go quiet
    task automatic wait_link(input int k);
        int n;
        for (n = 0; n < 400; n++) begin
            if (ecpp_periph_model_i.got.size() >= k && ecpp_periph_model_i.send.size() == 0
                && periph_clock_ack_n === 1'b1) break;
            @(posedge pclk);
        end
        if (n == 400) begin
            err_count++;
            stop_test();
        end
    endtask
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 13'h0;
        pwdata = 32'h0;
        periph_request_fault_n = 1'b1;
        printer_select = 1'b1;
        cfg_irq_sel = 3'h5;
        cfg_dma_sel = 3'h2;
        slow = 4'h0;
        err_count = 0;
        tests_run = 0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        check("idle pins", {host_clock_strobe_n, host_ack_autofeed_n, reverse_request_init_n,
              ecp_mode_select_in_n, pd_oe_n}, 32'h1A);
        rd("ecr", 13'h1008, 32'h11);
        rd("control", 13'h0008, 32'h00);
        rd("status", 13'h0004, 32'hD8);
        apb(1'b0, 13'h000C, 32'h0);
        check("slverr", e, 1'b1);
        apb(1'b1, 13'h1008, 32'hF0);
        rd("cap a", 13'h1000, 32'h10);
        rd("cap b", 13'h1004, 32'h2A);
        rd("status cfg", 13'h0004, 32'hD8);
        $display("test registers done");
        apb(1'b1, 13'h0008, 32'h04);
        apb(1'b1, 13'h1008, 32'h70);
        apb(1'b1, 13'h0000, 32'h12);
        slow <= 4'h2;
        apb(1'b1, 13'h1000, 32'hA5);
        apb(1'b1, 13'h1000, 32'h5A);
        wait_link(3);
        check("fwd addr", ecpp_periph_model_i.got[0], 32'h012);
        check("fwd d0", ecpp_periph_model_i.got[1], 32'h1A5);
        check("fwd d1", ecpp_periph_model_i.got[2], 32'h15A);
        check("select in", ecp_mode_select_in_n, 1'b1);
        rd("ecr fwd", 13'h1008, 32'h71);
        periph_request_fault_n <= 1'b0;
        @(posedge pclk);
        check("irq off", err_irq, 1'b0);
        apb(1'b1, 13'h1008, 32'h60);
        check("irq on", err_irq, 1'b1);
        periph_request_fault_n <= 1'b1;
        @(posedge pclk);
        $display("test forward done");
        apb(1'b1, 13'h1008, 32'h50);
        apb(1'b1, 13'h0008, 32'h24);
        apb(1'b1, 13'h1000, 32'hC3);
        wait_link(4);
        check("compat", ecpp_periph_model_i.got[3][7:0], 32'hC3);
        check("compat oe", pd_oe_n, 1'b0);
        $display("test compat done");
        apb(1'b1, 13'h1008, 32'h10);
        apb(1'b1, 13'h0008, 32'h20);
        ecpp_periph_model_i.send.push_back(9'h003);
        ecpp_periph_model_i.send.push_back(9'h133);
        ecpp_periph_model_i.send.push_back(9'h144);
        apb(1'b1, 13'h1008, 32'h70);
        wait_link(0);
        check("rev oe", pd_oe_n, 1'b1);
        for (i = 0; i < 4; i++) rd("rle", 13'h1000, 32'h33);
        rd("rev", 13'h1000, 32'h44);
        rd("ecr rev", 13'h1008, 32'h71);
        $display("test reverse done");
        apb(1'b1, 13'h0008, 32'h04);
        apb(1'b1, 13'h1008, 32'h10);
        apb(1'b1, 13'h1008, 32'hD0);
        for (i = 0; i < 17; i++) apb(1'b1, 13'h1000, 32'h80 + i);
        rd("full", 13'h1008, 32'hD2);
        for (i = 0; i < 16; i++) rd("test_fifo_port", 13'h1000, 32'h80 + i);
        rd("reread", 13'h1000, 32'h8F);
        rd("empty", 13'h1008, 32'hD1);
        apb(1'b1, 13'h1008, 32'hD8);
        check("dma", dma_req, 1'b1);
        check("clash", ecpp_periph_model_i.clash, 1'b0);
        $display("test fifo done");
        apb(1'b1, 13'h1008, 32'h30);
        apb(1'b1, 13'h0000, 32'h3C);
        rd("bidir data", 13'h0000, 32'h3C);
        apb(1'b1, 13'h0008, 32'h24);
        check("bidir in", pd_oe_n, 1'b1);
        $display("test bidir done");
        stop_test();
    end
endmodule
`default_nettype wire
